// file: verilog/synth_loop_pkg.sv
// Package with register map, field positions, reset values and widths of the loop control.
package synth_loop_pkg;
    // ==========================================================
    // Register word offsets (byte addresses)
    localparam logic [4:0] OFS_CHANNEL  = 5'h00;
    localparam logic [4:0] OFS_SPEEDUP  = 5'h04;
    localparam logic [4:0] OFS_ENABLE   = 5'h08;
    localparam logic [4:0] OFS_CONFIG   = 5'h0C;
    localparam logic [4:0] OFS_TEST     = 5'h10;
    localparam logic [4:0] OFS_STATUS   = 5'h14;
    // ==========================================================
    // Field positions
    localparam int POS_G_FIELD       = 0;
    localparam int POS_MAIN_POL      = 4;
    localparam int POS_AUX_POL       = 5;
    localparam int POS_REF_RATIO     = 8;
    localparam int POS_MAIN_EN       = 0;
    localparam int POS_AUX_EN        = 1;
    localparam int POS_IF_LOCK_EN    = 0;
    localparam int POS_ALT_SCHEME    = 1;
    localparam int POS_STANDBY       = 2;
    localparam int POS_IF_DIV        = 4;
    // ==========================================================
    // Widths and fixed values
    localparam int REF_RATIO_W       = 12;
    localparam int TEST_W            = 20;
    localparam int SYNC_W            = 9;
    localparam logic [3:0] SPEEDUP_LOW_ONES = 4'hF;
    localparam logic [3:0] IF_DIV_BASE      = 4'h6;
    // ==========================================================
    // Values after reset
    localparam logic [11:0] REF_RATIO_RST = 12'h001;
    localparam logic [3:0]  G_FIELD_RST   = 4'h0;
    localparam logic [1:0]  IF_DIV_RST    = 2'h0;
    localparam logic [19:0] TEST_RST      = 20'h00000;
    // ==========================================================
    // Test codes: the low nibble selects what drives the lock pin, bits 7:4 and 11:8 select the pump tests
    localparam logic [3:0] TST_LOCK      = 4'h1;
    localparam logic [3:0] TST_FRAC_OVF  = 4'h2;
    localparam logic [3:0] TST_AUX_DIV   = 4'h3;
    localparam logic [3:0] TST_MAIN_DIV  = 4'h4;
    localparam logic [3:0] TST_REF_DIV   = 4'h5;
    localparam logic [3:0] TST_FORCE_HI  = 4'h6;
    localparam logic [3:0] TST_FORCE_LO  = 4'h7;
    localparam logic [3:0] TST_PUMP_UP   = 4'h1;
    localparam logic [3:0] TST_PUMP_DN   = 4'h2;
    localparam logic [3:0] TST_FRAC_PUMP = 4'h1;
endpackage : synth_loop_pkg

// file: verilog/synth_loop_control.sv
// Digital control of loop enables, speed-up, lock indicator, test field and IF enable.
//
// Function
// - Disabled loop turns off its input and pumps.
// - Both loops off also turns off reference.
// - Word loading never waits on the reference.
// - Speed-up boosts proportional, enables integral pump.
// - Alternate duration is count times divided reference period.
// - Count is upper nibble plus fixed ones.
// - Standard speed-up follows load pulse after channel.
// - Lock is AND of three qualified terms.
// - Nonzero test word reroutes lock pin.
// - Zero test word or config write clears tests.
// - Test nibbles select the listed test modes.
// - Load pulse falling edge sets IF enable.
// - Transmit enable rise leaves IF enable alone.
// - Transmit enable fall clears IF enable.
// - Standby forces IF lock term to locked.
// - IF divider ratio six to nine.
// - Master clock always, second clock gated.
// - Polarity bit zero positive, one negative.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
module synth_loop_control
    import synth_loop_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ref_clk_i,
    input  wire logic        load_pulse_i,
    input  wire logic        transmit_enable_in_i,
    input  wire logic        if_vco_i,
    input  wire logic        main_lock_flag_i,
    input  wire logic        aux_lock_flag_i,
    input  wire logic        if_loop_lock_flag_i,
    input  wire logic        frac_overflow_i,
    input  wire logic        aux_div_out_i,
    output logic             main_stage_on_o,
    output logic             aux_stage_on_o,
    output logic             ref_chain_on_o,
    output logic             main_pd_polarity_o,
    output logic             aux_pd_polarity_o,
    output logic             speedup_o,
    output logic             integral_pump_on_o,
    output logic             lock_o,
    output logic             if_synth_enable_o,
    output logic             modulator_on_o,
    output logic             if_div_out_o,
    output logic             mclk_o,
    output logic             rclk_o,
    output logic             pump_force_up_o,
    output logic             pump_force_down_o,
    output logic             frac_pump_test_o,
    output logic             main_prescaler_bypass_o,
    output logic             aux_prescaler_bypass_o,
    output logic             ref_chain_test_o
);
    // ==========================================================
    // Pin synchronisers
    logic [SYNC_W-1:0] pin_meta;
    logic [SYNC_W-1:0] pin_sync;
    logic [SYNC_W-1:0] pin_prev;
    wire  [SYNC_W-1:0] pins_raw = {aux_div_out_i, frac_overflow_i, if_loop_lock_flag_i,
                                   aux_lock_flag_i, main_lock_flag_i, if_vco_i,
                                   transmit_enable_in_i, load_pulse_i, ref_clk_i};

    always_ff @(posedge clk_i) begin
        pin_meta <= pins_raw;
        pin_sync <= pin_meta;
        pin_prev <= pin_sync;
    end

    wire ref_lvl     = pin_sync[0];
    wire ref_rise    = pin_sync[0] & ~pin_prev[0];
    wire strobe_lvl  = pin_sync[1];
    wire strobe_fall = ~pin_sync[1] & pin_prev[1];
    wire transmit_enable_in_lvl    = pin_sync[2];
    wire transmit_enable_in_fall   = ~pin_sync[2] & pin_prev[2];
    wire vco_rise    = pin_sync[3] & ~pin_prev[3];
    wire main_lock   = pin_sync[4];
    wire aux_lock    = pin_sync[5];
    wire if_lock     = pin_sync[6];
    wire frac_ovf    = pin_sync[7];
    wire aux_div     = pin_sync[8];

    // ==========================================================
    // Register bus
    logic                   main_loop_enable;
    logic                   aux_loop_enable;
    logic                   if_lock_term_enable;
    logic                   alternate_scheme;
    logic                   standby;
    logic [1:0]             if_div_sel;
    logic [3:0]             g_field;
    logic                   main_pd_polarity;
    logic                   aux_pd_polarity;
    logic [REF_RATIO_W-1:0] ref_divide_ratio;
    logic [TEST_W-1:0]      test_select_bits;
    logic [7:0]             speedup_count;
    logic                   std_armed;
    logic                   std_speedup;

    wire bus_req   = wb_cyc_i & wb_stb_i;
    wire wr_commit = bus_req & wb_we_i & wb_ack_o;
    wire wr_chan   = wr_commit & (wb_adr_i == OFS_CHANNEL);
    wire wr_spd    = wr_commit & (wb_adr_i == OFS_SPEEDUP);
    wire wr_en     = wr_commit & (wb_adr_i == OFS_ENABLE);
    wire wr_cfg    = wr_commit & (wb_adr_i == OFS_CONFIG);
    wire wr_test   = wr_commit & (wb_adr_i == OFS_TEST);
    wire lo_lane   = wb_sel_i[0];
    wire [TEST_W-1:0] test_wdata = {wb_sel_i[2] ? wb_dat_i[19:16] : test_select_bits[19:16],
                                    wb_sel_i[1] ? wb_dat_i[15:8]  : test_select_bits[15:8],
                                    wb_sel_i[0] ? wb_dat_i[7:0]   : test_select_bits[7:0]};

    wire alt_active    = speedup_count != 8'h00;
    wire speedup       = alternate_scheme ? alt_active : std_speedup;
    wire if_synth_en;
    wire lock_fn;

    wire [31:0] status_word = {26'h0000000, speedup, if_synth_en, transmit_enable_in_lvl,
                               lock_fn, |test_select_bits, ref_chain_on_o};
    logic [31:0] next_rdata;

    always_comb begin
        case (wb_adr_i)
            OFS_SPEEDUP: next_rdata = {12'h000, ref_divide_ratio, 2'h0, aux_pd_polarity,
                                       main_pd_polarity, g_field};
            OFS_ENABLE:  next_rdata = {30'h00000000, aux_loop_enable, main_loop_enable};
            OFS_CONFIG:  next_rdata = {26'h0000000, if_div_sel, 1'b0, standby,
                                       alternate_scheme, if_lock_term_enable};
            OFS_TEST:    next_rdata = {12'h000, test_select_bits};
            OFS_STATUS:  next_rdata = status_word;
            default:     next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            wb_dat_o <= next_rdata;
        end
    end

    // word loading runs on the system clock only, independent of the reference.
    // reset clears enables and the test field.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_loop_enable    <= 1'b0;
            aux_loop_enable     <= 1'b0;
            if_lock_term_enable <= 1'b0;
            alternate_scheme    <= 1'b0;
            standby             <= 1'b0;
            if_div_sel          <= IF_DIV_RST;
            g_field             <= G_FIELD_RST;
            main_pd_polarity    <= 1'b0;
            aux_pd_polarity     <= 1'b0;
            ref_divide_ratio    <= REF_RATIO_RST;
            test_select_bits    <= TEST_RST;
        end else begin
            if (wr_en && lo_lane) begin
                main_loop_enable <= wb_dat_i[POS_MAIN_EN];
                aux_loop_enable  <= wb_dat_i[POS_AUX_EN];
            end
            if (wr_spd && lo_lane) begin
                g_field          <= wb_dat_i[POS_G_FIELD +: 4];
                main_pd_polarity <= wb_dat_i[POS_MAIN_POL];
                aux_pd_polarity  <= wb_dat_i[POS_AUX_POL];
            end
            if (wr_spd && wb_sel_i[1]) begin
                ref_divide_ratio <= wb_dat_i[POS_REF_RATIO +: REF_RATIO_W];
            end
            if (wr_cfg && lo_lane) begin
                if_lock_term_enable <= wb_dat_i[POS_IF_LOCK_EN];
                alternate_scheme    <= wb_dat_i[POS_ALT_SCHEME];
                standby             <= wb_dat_i[POS_STANDBY];
                if_div_sel          <= wb_dat_i[POS_IF_DIV +: 2];
            end
            // a config write clears the tests; a zero test write turns them off.
            if (wr_cfg) begin
                test_select_bits <= TEST_RST;
            end else if (wr_test) begin
                test_select_bits <= test_wdata;
            end
        end
    end

    // ==========================================================
    // Loop and reference enables
    // a cleared enable switches off that loop's stage and pump bias.
    assign main_stage_on_o    = main_loop_enable;
    assign aux_stage_on_o     = aux_loop_enable;
    // reference chain stays on while either loop is enabled.
    assign ref_chain_on_o     = main_loop_enable | aux_loop_enable;
    // polarity bits pass to the detectors, one meaning negative slope.
    assign main_pd_polarity_o = main_pd_polarity;
    assign aux_pd_polarity_o  = aux_pd_polarity;

    // ==========================================================
    // Reference divider
    logic [REF_RATIO_W-1:0] ref_count;
    wire ref_tick = ref_chain_on_o & ref_rise & (ref_count <= 12'h001);

    always_ff @(posedge clk_i) begin
        if (rst_i || !ref_chain_on_o) begin
            ref_count <= REF_RATIO_RST;
        end else if (ref_rise) begin
            ref_count <= (ref_count <= 12'h001) ? ref_divide_ratio : ref_count - 12'h001;
        end
    end

    // ==========================================================
    // Speed-up timing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            speedup_count <= 8'h00;
            std_armed     <= 1'b0;
            std_speedup   <= 1'b0;
        end else begin
            // the alternate timer starts at each channel word load.
            // the count is the programmed nibble with low ones.
            if (wr_chan) begin
                speedup_count <= {g_field, SPEEDUP_LOW_ONES};
            end else if (alt_active && ref_tick) begin
                speedup_count <= speedup_count - 8'h01;
            end
            // speed-up follows the load pulse after a channel write.
            if (wr_chan) begin
                std_armed <= 1'b1;
            end else if (strobe_lvl && std_armed) begin
                std_armed <= 1'b0;
            end
            if (strobe_lvl && std_armed) begin
                std_speedup <= 1'b1;
            end else if (!strobe_lvl) begin
                std_speedup <= 1'b0;
            end
        end
    end

    // speed-up boosts the proportional pump and turns on the integral pump.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            speedup_o          <= 1'b0;
            integral_pump_on_o <= 1'b0;
        end else begin
            speedup_o          <= speedup & main_loop_enable;
            integral_pump_on_o <= speedup & main_loop_enable;
        end
    end

    // ==========================================================
    // IF synthesizer enable flip-flops
    logic if_ff1;
    // The second flip-flop only makes a clear pulse; here that pulse is transmit_enable_in_fall.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            if_ff1 <= 1'b0;
        // transmit enable falling edge clears the enable.
        end else if (transmit_enable_in_fall) begin
            if_ff1 <= 1'b0;
        // load pulse falling edge sets the enable.
        end else if (strobe_fall) begin
            if_ff1 <= 1'b1;
        end
    end
    // a rising transmit enable has no path into the enable flip-flop.
    assign if_synth_en       = if_ff1;
    assign if_synth_enable_o = if_ff1;
    assign modulator_on_o    = if_ff1 & transmit_enable_in_lvl;

    // ==========================================================
    // IF feedback divider
    // ratio is six plus the two-bit field.
    logic [3:0] if_div_count;
    wire  [3:0] if_div_ratio = IF_DIV_BASE + {2'b00, if_div_sel};

    always_ff @(posedge clk_i) begin
        if (rst_i || !if_ff1) begin
            if_div_count <= 4'h0;
            if_div_out_o <= 1'b0;
        end else if (vco_rise) begin
            if_div_count <= (if_div_count >= if_div_ratio - 4'h1) ? 4'h0 : if_div_count + 4'h1;
            if_div_out_o <= (if_div_count >= if_div_ratio - 4'h1) ||
                            (if_div_count < {1'b0, if_div_ratio[3:1]} - 4'h1);
        end
    end

    // ==========================================================
    // Lock indicator and test routing
    // standby forces the IF lock term to locked.
    wire if_term   = if_lock | ~if_lock_term_enable | standby;
    // AND of the three qualified lock terms.
    assign lock_fn = (main_lock | ~main_loop_enable) & (aux_lock | ~aux_loop_enable) & if_term;
    wire test_on   = |test_select_bits;
    wire [3:0] tst_node = test_select_bits[3:0];
    logic test_pin;

    // the low nibble picks the node shown on the lock pin.
    always_comb begin
        case (tst_node)
            TST_LOCK:     test_pin = lock_fn;
            TST_FRAC_OVF: test_pin = frac_ovf;
            TST_AUX_DIV:  test_pin = aux_div;
            TST_MAIN_DIV: test_pin = if_div_out_o;
            TST_REF_DIV:  test_pin = ref_tick;
            TST_FORCE_HI: test_pin = 1'b1;
            TST_FORCE_LO: test_pin = 1'b0;
            default:      test_pin = 1'b0;
        endcase
    end

    // with tests on the lock pin shows the selected node.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_o                  <= 1'b0;
            pump_force_up_o         <= 1'b0;
            pump_force_down_o       <= 1'b0;
            frac_pump_test_o        <= 1'b0;
            main_prescaler_bypass_o <= 1'b0;
            aux_prescaler_bypass_o  <= 1'b0;
            ref_chain_test_o        <= 1'b0;
        end else begin
            lock_o                  <= test_on ? test_pin : lock_fn;
            // upper nibbles drive the pump, prescaler and chain tests.
            pump_force_up_o         <= test_select_bits[7:4] == TST_PUMP_UP;
            pump_force_down_o       <= test_select_bits[7:4] == TST_PUMP_DN;
            frac_pump_test_o        <= test_select_bits[11:8] == TST_FRAC_PUMP;
            main_prescaler_bypass_o <= test_select_bits[12];
            aux_prescaler_bypass_o  <= test_select_bits[13];
            ref_chain_test_o        <= test_select_bits[16];
        end
    end

    // ==========================================================
    // Clock buffers
    // master clock always follows the reference; second clock is gated.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mclk_o <= 1'b0;
            rclk_o <= 1'b0;
        end else begin
            mclk_o <= ref_lvl;
            rclk_o <= ref_lvl & (standby | transmit_enable_in_lvl);
        end
    end
endmodule : synth_loop_control

// file: testbench/synth_loop_control_props.sv
// Port-level checker of the loop control block.
`timescale 1ns/1ns
module synth_loop_control_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic load_pulse_i,
    input wire logic transmit_enable_in_i,
    input wire logic main_stage_on_o,
    input wire logic aux_stage_on_o,
    input wire logic ref_chain_on_o,
    input wire logic speedup_o,
    input wire logic integral_pump_on_o,
    input wire logic if_synth_enable_o,
    input wire logic modulator_on_o,
    input wire logic mclk_o,
    input wire logic rclk_o,
    input wire logic pump_force_up_o,
    input wire logic pump_force_down_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // Port relations
    ref_gate_a: assert property (ref_chain_on_o == (main_stage_on_o | aux_stage_on_o))
        else $error("reference chain wrong");
    pump_pair_a: assert property (speedup_o == integral_pump_on_o)
        else $error("integral pump differs from speed-up");
    boost_main_a: assert property (speedup_o |-> $past(main_stage_on_o))
        else $error("speed-up with main loop disabled");
    mod_gate_a: assert property (modulator_on_o |-> if_synth_enable_o)
        else $error("modulator on without IF enable");
    load_set_a: assert property ($fell(load_pulse_i) |-> ##[2:5] if_synth_enable_o)
        else $error("load pulse fall did not set IF enable");
    transmit_enable_in_clear_a: assert property ($fell(transmit_enable_in_i) |-> ##[2:5]
        !if_synth_enable_o)
        else $error("transmit enable fall did not clear IF enable");
    rclk_gate_a: assert property (rclk_o |-> mclk_o)
        else $error("second clock not gated");
    pump_excl_a: assert property (!(pump_force_up_o && pump_force_down_o))
        else $error("pumps forced up and down together");
    ack_pulse_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one pulse");
    reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
        !if_synth_enable_o && !ref_chain_on_o && !speedup_o)
        else $error("outputs not cleared by reset");
    cover property ($rose(speedup_o));
    cover property ($fell(if_synth_enable_o));
    cover property (rclk_o);
endmodule : synth_loop_control_props
bind synth_loop_control synth_loop_control_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .load_pulse_i, .transmit_enable_in_i, .main_stage_on_o, .aux_stage_on_o,
    .ref_chain_on_o, .speedup_o, .integral_pump_on_o, .if_synth_enable_o, .modulator_on_o,
    .mclk_o, .rclk_o, .pump_force_up_o, .pump_force_down_o);

// file: testbench/synth_loop_partner.sv
// Baseband controller model: reference oscillator, load pulse and transmit enable.
`timescale 1ns/1ns
module synth_loop_partner (
    input  wire logic clk_i,
    input  wire logic if_synth_enable_i,
    output logic      ref_clk_o,
    output logic      load_pulse_o,
    output logic      transmit_enable_o
);
    // ==========================================
    // Free-running reference, 125 ns period
    initial begin
        ref_clk_o = 1'b0;
        load_pulse_o = 1'b0;
        transmit_enable_o = 1'b0;
        #3;
        forever begin
            #62 ref_clk_o = 1'b1;
            #63 ref_clk_o = 1'b0;
        end
    end
    task automatic set_load(input logic v);
        @(posedge clk_i);
        load_pulse_o <= v;
    endtask : set_load
    task automatic tx(input logic on);
        int k;
        k = 0;
        while (on && if_synth_enable_i !== 1'b1 && k < 50) begin
            @(posedge clk_i);
            k++;
        end
        @(posedge clk_i);
        transmit_enable_o <= on;
    endtask : tx
endmodule : synth_loop_partner

// file: testbench/synth_loop_control_bench.sv
// Self-checking bench of the loop control block.
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
module synth_loop_control_bench;
    import synth_loop_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ref_clk_i, load_pulse_i;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, r, rd_e, d;
    logic transmit_enable_in_i, main_lock_flag_i, aux_lock_flag_i, if_loop_lock_flag_i;
    logic main_stage_on_o, aux_stage_on_o, ref_chain_on_o, main_pd_polarity_o;
    logic aux_pd_polarity_o, speedup_o, integral_pump_on_o, lock_o, if_synth_enable_o;
    logic modulator_on_o, if_div_out_o, mclk_o, rclk_o, pump_force_up_o, pump_force_down_o;
    logic frac_pump_test_o, main_prescaler_bypass_o, aux_prescaler_bypass_o, ref_chain_test_o;
    logic [31:0] rd_q[$];
    logic [5:0] pin_q[$];
    logic [5:0] pn;
    logic [19:0] tv[8] = '{20'h6, 20'h7, 20'h10, 20'h20, 20'h100, 20'h1000, 20'h2000, 20'h10000};
    int ti[8] = '{0, 0, 10, 11, 12, 13, 14, 15};
    logic [7:0] te = 8'hFD;
    int n_mismatch = 0;
    int checks_done = 0;
    int n, m, c;
    event look;
    // Observed pins by index, lock_o at bit 0 and rclk_o at bit 16.
    wire [16:0] obs = {rclk_o, ref_chain_test_o, aux_prescaler_bypass_o, main_prescaler_bypass_o,
        frac_pump_test_o, pump_force_down_o, pump_force_up_o, modulator_on_o, if_synth_enable_o,
        aux_pd_polarity_o, main_pd_polarity_o, ref_chain_on_o, aux_stage_on_o, main_stage_on_o,
        integral_pump_on_o, speedup_o, lock_o};
    synth_loop_control u_synth_loop_control (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ref_clk_i, .load_pulse_i,
        .transmit_enable_in_i, .if_vco_i(ref_clk_i), .main_lock_flag_i, .aux_lock_flag_i,
        .if_loop_lock_flag_i, .frac_overflow_i(mclk_o), .aux_div_out_i(rclk_o), .main_stage_on_o,
        .aux_stage_on_o, .ref_chain_on_o, .main_pd_polarity_o, .aux_pd_polarity_o, .speedup_o,
        .integral_pump_on_o, .lock_o, .if_synth_enable_o, .modulator_on_o, .if_div_out_o,
        .mclk_o, .rclk_o, .pump_force_up_o, .pump_force_down_o, .frac_pump_test_o,
        .main_prescaler_bypass_o, .aux_prescaler_bypass_o, .ref_chain_test_o);
    synth_loop_partner u_partner (.clk_i, .if_synth_enable_i(if_synth_enable_o),
        .ref_clk_o(ref_clk_i), .load_pulse_o(load_pulse_i),
        .transmit_enable_o(transmit_enable_in_i));
    // ==========================================
    // Result watchers
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
            rd_e = rd_q.pop_front();
            `CHK(wb_dat_o, rd_e)
        end
    end
    always @(posedge if_div_out_o) c++;
    always @(look) begin
        pn = pin_q.pop_front();
        `CHK(obs[pn[5:1]], pn[0])
    end
    // ==========================================
    // Drivers
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] dv);
        int k;
        k = 0;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= dv;
        wb_sel_i <= w ? 4'hF : 4'($urandom);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            tally_and_finish();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    task automatic note(input int i, input logic v);
        pin_q.push_back({i[4:0], v});
        @(negedge clk_i);
        ->look;
        @(posedge clk_i);
    endtask : note
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #900000;
        n_mismatch++;
        tally_and_finish();
    end
    // ==========================================
    // Scenarios
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 41'h0};
        {main_lock_flag_i, aux_lock_flag_i, if_loop_lock_flag_i} = 3'h0;
        void'($urandom(32'hF58A));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_STATUS, 32'h4);
        rd(OFS_TEST, 32'h0);
        note(8, 1'b0);
        bus(5'h18, 1'b1, 32'hFFFF_FFFF);
        bus(OFS_STATUS, 1'b1, 32'hFFFF_FFFF);
        rd(5'h18, 32'h0);
        rd(OFS_ENABLE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            d = {12'h0, 12'h001, 2'b00, i[1:0], r[3:0]};
            bus(OFS_SPEEDUP, 1'b1, d);
            rd(OFS_SPEEDUP, d);
            note(6, i[0]);
            note(7, i[1]);
        end
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            bus(OFS_ENABLE, 1'b1, {30'h0, i[1:0]});
            bus(OFS_CONFIG, 1'b1, {29'h0, i[2], 1'b0, r[2] | i[2]});
            {main_lock_flag_i, aux_lock_flag_i, if_loop_lock_flag_i} <= {r[4], r[5], r[6] & !i[2]};
            repeat (6) @(posedge clk_i);
            note(3, i[0]);
            note(4, i[1]);
            note(5, |i[1:0]);
            note(0, (r[4] | !i[0]) & (r[5] | !i[1]) & (r[6] | !r[2] | i[2]));
        end
        n = 0;
        while (rclk_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        `CHK(rclk_o, 1'b1)
        {main_lock_flag_i, aux_lock_flag_i, if_loop_lock_flag_i} <= 3'h7;
        for (int i = 0; i < 8; i++) begin
            bus(OFS_TEST, 1'b1, {12'h0, tv[i]});
            repeat (6) @(posedge clk_i);
            note(ti[i], te[i]);
        end
        bus(OFS_CONFIG, 1'b1, 32'h1);
        note(15, 1'b0);
        bus(OFS_TEST, 1'b1, 32'h7);
        repeat (6) @(posedge clk_i);
        note(0, 1'b0);
        bus(OFS_TEST, 1'b1, 32'h0);
        repeat (6) @(posedge clk_i);
        note(0, 1'b1);
        bus(OFS_ENABLE, 1'b1, 32'h1);
        bus(OFS_CONFIG, 1'b1, 32'h2);
        for (int i = 0; i < 2; i++) begin
            c = i ? 47 : 15;
            bus(OFS_SPEEDUP, 1'b1, i ? 32'h202 : 32'h100);
            bus(OFS_CHANNEL, 1'b1, 32'h0);
            note(2, 1'b1);
            n = 1;
            while (speedup_o === 1'b1 && n < 20000) begin
                @(posedge clk_i);
                n++;
            end
            m = c * (i + 1) * 25 / 2;
            `CHK(n > m - 30 && n < m + 30, 1'b1)
        end
        bus(OFS_CONFIG, 1'b1, 32'h0);
        bus(OFS_CHANNEL, 1'b1, 32'h0);
        u_partner.set_load(1'b1);
        repeat (8) @(posedge clk_i);
        note(1, 1'b1);
        u_partner.set_load(1'b0);
        repeat (6) @(posedge clk_i);
        note(1, 1'b0);
        note(8, 1'b1);
        u_partner.tx(1'b1);
        repeat (6) @(posedge clk_i);
        note(8, 1'b1);
        note(9, 1'b1);
        c = 0;
        repeat (600) @(posedge clk_i);
        `CHK(c, 8)
        u_partner.tx(1'b0);
        repeat (6) @(posedge clk_i);
        note(8, 1'b0);
        note(9, 1'b0);
        tally_and_finish();
    end
endmodule : synth_loop_control_bench
